// file: verilog/qec_encoder.sv
// quadrature encoder control block: position counter, timer mode, avalon-mm slave
// assumes one 125 MHz clock, async pins from an incremental encoder with index
//
// Contract
// - mode 110: x4 count, index resets counter
// - mode 100: x2 count, index resets counter
// - modes 011 and 010 disable counting
// - mode 000 turns encoder and timer off
// - prescaler used only in timer mode
// - count error sets control bit 15
// - count errors only in modes 110, 100
// - bit 13 halts block during idle
// - bit 12 shows live index pin level
// - direction bit read-only in encoder modes
// - bit 7 swaps phase a and b
// - index reset enable only in 100, 110
// - encoder modes take direction from decoder
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ps
module qec_encoder #(
  parameter int CNT_W = 16                       // position counter width
) (
  input logic i_clk,                             // 125 MHz clock
  input logic i_rst_b,                           // async reset, active low
  input logic [qec_pkg::AW-1:0] i_avs_address,   // byte address
  input logic i_avs_read,                        // read request
  input logic i_avs_write,                       // write request
  input logic [31:0] i_avs_writedata,            // write data
  input logic [3:0] i_avs_byteenable,            // byte lanes
  output logic [31:0] o_avs_readdata,            // read data, registered
  output logic o_avs_waitrequest,                // stall
  input logic i_pha,                             // encoder phase a pin
  input logic i_phb,                             // encoder phase b pin
  input logic i_idx,                             // encoder index pin
  input logic i_idle,                            // device in idle mode
  output logic o_dir,                            // direction pin value
  output logic o_dir_oe,                         // direction pin enable
  output logic o_irq                             // level interrupt
);
  import qec_pkg::*;

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (CNT_W < 8 || CNT_W > 32) begin : g_bad_width
    $error("counter width must be 8 to 32");
  end

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  qec_dec_if dif ();                             // decoder link
  logic [15:0] ctrl_q;                           // encoder_control
  logic [15:0] ctrl_d;                           // its next value
  logic [CNT_W-1:0] pos_q;                       // position counter
  logic [CNT_W-1:0] max_q;                       // max_count_value
  logic [ST_W-1:0] stat_q;                       // sticky events
  logic [ST_W-1:0] mask_q;                       // event mask
  logic [ST_W-1:0] evt_w;                        // events this cycle
  logic [7:0] pre_q;                             // timer prescaler
  logic [7:0] pre_last;                          // prescaler terminal value
  logic ack_q;                                   // bus answer cycle
  logic [31:0] rdata_q;                          // read data
  logic [31:0] be_m;                             // byte-lane mask
  logic [15:0] cw_m;                             // control write mask
  qec_mode_t mode;                               // current mode
  logic enc_mode;                                // any encoder mode
  logic idx_mode;                                // index-reset encoder mode
  logic tmr_mode;                                // timer mode
  logic run;                                     // not halted by idle
  logic acc;                                     // request taken this edge
  logic wr_ctrl;                                 // control write
  logic wr_pos;                                  // position write
  logic wr_max;                                  // max write
  logic wr_stat;                                 // status write
  logic wr_mask;                                 // mask write
  logic tmr_in;                                  // timer input pulse
  logic tmr_step;                                // timer count step
  logic cnt_step;                                // counter step
  logic cnt_up;                                  // counter direction
  logic at_max;                                  // counter at max
  logic at_zero;                                 // counter at zero
  logic wrap;                                    // wrap at max or zero
  logic idx_rst;                                 // index reset of counter
  logic err_evt;                                 // count error event

  // ----------------------------------------
  // pin decoder
  // ----------------------------------------
  qec_decode u_dec (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pha(i_pha),
    .i_phb(i_phb),
    .i_idx(i_idx),
    .dif(dif)
  );

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign mode = qec_mode_t'(ctrl_q[B_MODE +: 3]);
  assign enc_mode = mode[2];                     // 1xx
  assign idx_mode = mode[2] & ~mode[0];          // 110 or 100
  assign tmr_mode = (mode == MODE_TMR);
  assign run = ~(i_idle & ctrl_q[B_IDLE]);       // idle halt
  assign dif.en = enc_mode & run;                // 0xx never decodes
  assign dif.swap = ctrl_q[B_SWAP];
  assign dif.x4 = mode[1];                       // x4 in 11x, x2 in 10x

  // ----------------------------------------
  // avalon-mm slave: one wait cycle on every access
  // ----------------------------------------
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign acc = ack_q & (i_avs_read | i_avs_write);
  assign wr_ctrl = acc & i_avs_write & (i_avs_address == OFF_CTRL);
  assign wr_pos = acc & i_avs_write & (i_avs_address == OFF_POS);
  assign wr_max = acc & i_avs_write & (i_avs_address == OFF_MAX);
  assign wr_stat = acc & i_avs_write & (i_avs_address == OFF_STAT);
  assign wr_mask = acc & i_avs_write & (i_avs_address == OFF_MASK);
  assign be_m = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                 {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign o_avs_readdata = rdata_q;

  // answer flag: high for the cycle that lowers waitrequest
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
    end
  end

  // read data captured in the wait cycle, unmapped reads give zero
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_avs_read && !ack_q) begin
      case (i_avs_address)
        OFF_CTRL: begin
          // live index level in bit 12
          rdata_q <= {16'h0000, ctrl_q[15:13], dif.idx_lvl, ctrl_q[11:0]};
        end
        OFF_POS: rdata_q <= 32'(pos_q);
        OFF_MAX: rdata_q <= 32'(max_q);
        OFF_STAT: rdata_q <= 32'(stat_q);
        OFF_MASK: rdata_q <= 32'(mask_q);
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // direction bit writable only in timer mode
  assign cw_m = be_m[15:0] & CTRL_WMASK & ~(tmr_mode ? 16'h0000 : 16'h0800);

  // next control value: software fields, hardware direction and error flag
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = (ctrl_q & ~cw_m) | (i_avs_writedata[15:0] & cw_m);
      // error flag cleared only by writing zero
      if (i_avs_byteenable[1] && !i_avs_writedata[B_ERR]) begin
        ctrl_d[B_ERR] = 1'b0;
      end
    end
    if (enc_mode && run && dif.step) begin
      // decoder direction, select bit ignored
      ctrl_d[B_DIR] = dif.up;
    end else if (tmr_mode && ctrl_q[B_DSRC]) begin
      // timer direction from phase b level
      ctrl_d[B_DIR] = dif.phb_lvl;
    end
    if (err_evt) begin
      ctrl_d[B_ERR] = 1'b1;                      // set wins over clear
    end
    ctrl_d[B_INDEX] = 1'b0;                      // stored as zero, read live
    ctrl_d[14] = 1'b0;                           // unimplemented
  end

  // control register update
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // direction pin driven from the status bit
  assign o_dir = ctrl_q[B_DIR];
  assign o_dir_oe = ctrl_q[B_DOUT];

  // ----------------------------------------
  // timer mode prescaler
  // ----------------------------------------
  always_comb begin
    case (ctrl_q[B_PS +: 2])
      2'b00: pre_last = PS_L0;
      2'b01: pre_last = PS_L1;
      2'b10: pre_last = PS_L2;
      2'b11: pre_last = PS_L3;
      default: pre_last = PS_L0;
    endcase
  end

  // internal clock or phase a edges, optionally gated by phase a high
  assign tmr_in = tmr_mode & run & (ctrl_q[B_TCS] ? dif.pha_rise : 1'b1)
                  & (ctrl_q[B_GATE] ? dif.pha_lvl : 1'b1);
  assign tmr_step = tmr_in & (pre_q == pre_last);

  // prescaler held clear outside timer mode
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_q <= 8'h00;
    end else if (!tmr_mode) begin
      pre_q <= 8'h00;
    end else if (tmr_in) begin
      pre_q <= (pre_q == pre_last) ? 8'h00 : pre_q + 8'h01;
    end
  end

  // ----------------------------------------
  // position counter
  // ----------------------------------------
  assign cnt_step = (enc_mode & run & dif.step) | tmr_step;
  assign cnt_up = enc_mode ? dif.up : ctrl_q[B_DIR];
  assign at_max = (pos_q == max_q);
  assign at_zero = (pos_q == '0);
  assign wrap = cnt_step & (cnt_up ? at_max : at_zero);
  // index reset honoured only in 100 and 110
  assign idx_rst = idx_mode & run & ctrl_q[B_INDEX_RESET_ENABLE] & dif.idx_rise;
  // overrun without an index in index modes only
  assign err_evt = idx_mode & wrap & ~idx_rst;

  // software write first, then index reset, then counting
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pos_q <= '0;
    end else if (wr_pos) begin
      pos_q <= (pos_q & ~be_m[CNT_W-1:0]) | (i_avs_writedata[CNT_W-1:0] & be_m[CNT_W-1:0]);
    end else if (idx_rst) begin
      pos_q <= '0;
    end else if (cnt_step) begin
      if (cnt_up) begin
        pos_q <= at_max ? '0 : pos_q + 1'b1;     // max match reset
      end else begin
        pos_q <= at_zero ? max_q : pos_q - 1'b1;
      end
    end
  end

  // max count register, all ones at reset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      max_q <= '1;
    end else if (wr_max) begin
      max_q <= (max_q & ~be_m[CNT_W-1:0]) | (i_avs_writedata[CNT_W-1:0] & be_m[CNT_W-1:0]);
    end
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  assign evt_w = {idx_rst, wrap, err_evt};

  // sticky status, write one clears, new event wins
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat_q <= '0;
    end else begin
      stat_q <= evt_w | (stat_q & ~((wr_stat && i_avs_byteenable[0]) ?
                                    i_avs_writedata[ST_W-1:0] : 3'h0));
    end
  end

  // mask register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_q <= MASK_RST;
    end else if (wr_mask && i_avs_byteenable[0]) begin
      mask_q <= i_avs_writedata[ST_W-1:0];
    end
  end

  assign o_irq = |(stat_q & mask_q);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  chk_x4_max_wrap: assert property (
    (mode == MODE_X4MAX && cnt_step && cnt_up && at_max && !wr_pos) |=> pos_q == '0)
    else $error("x4 max match did not reset counter");

  chk_x4_index_reset: assert property (
    (mode == MODE_X4IDX && run && ctrl_q[B_INDEX_RESET_ENABLE] && dif.idx_rise && !wr_pos)
    |=> pos_q == '0)
    else $error("x4 index pulse did not reset counter");

  chk_x2_under_wrap: assert property (
    (mode == MODE_X2MAX && cnt_step && !cnt_up && at_zero && !wr_pos && !wr_max)
    |=> pos_q == $past(max_q))
    else $error("x2 underflow did not load max");

  chk_x2_index_reset: assert property (
    (mode == MODE_X2IDX && run && ctrl_q[B_INDEX_RESET_ENABLE] && dif.idx_rise && !wr_pos)
    |=> pos_q == '0)
    else $error("x2 index pulse did not reset counter");

  chk_off_no_count: assert property (
    (!mode[2] && !tmr_mode && !wr_pos) |=> $stable(pos_q))
    else $error("counter moved while disabled");

  chk_timer_count_up: assert property (
    (tmr_step && ctrl_q[B_DIR] && !at_max && !wr_pos) |=> pos_q == $past(pos_q) + 1'b1)
    else $error("timer step did not increment");

  chk_prescale_unused: assert property (
    (!tmr_mode) |=> pre_q == 8'h00)
    else $error("prescaler ran outside timer mode");

  chk_error_flag_set: assert property (
    err_evt |=> ctrl_q[B_ERR])
    else $error("count error did not set flag");

  chk_error_modes_only: assert property (
    (!idx_mode && !(wr_ctrl && i_avs_writedata[B_ERR])) |=> !$rose(ctrl_q[B_ERR]))
    else $error("count error outside index modes");

  chk_idle_halt: assert property (
    (i_idle && ctrl_q[B_IDLE] && !wr_pos) |=> $stable(pos_q))
    else $error("counter moved during idle halt");

  chk_index_read: assert property (
    (i_avs_read && !ack_q && i_avs_address == OFF_CTRL)
    |=> rdata_q[B_INDEX] == $past(dif.idx_lvl))
    else $error("index bit does not show pin level");

  chk_dir_read_only: assert property (
    (wr_ctrl && enc_mode && !(run && dif.step)) |=> $stable(ctrl_q[B_DIR]))
    else $error("direction bit written in encoder mode");

  chk_dir_from_decoder: assert property (
    (enc_mode && run && dif.step) |=> ctrl_q[B_DIR] == $past(dif.up) && o_dir == ctrl_q[B_DIR])
    else $error("direction not taken from decoder");

endmodule

// file: verilog/qec_pkg.sv
// package of the quadrature encoder control block: register map, fields, modes
// assumes a 32-bit avalon-mm slave with byte addresses, one register per word
package qec_pkg;

  // ----------------------------------------
  // bus geometry and register offsets
  // ----------------------------------------
  localparam int AW = 5;                        // byte address width
  localparam logic [AW-1:0] OFF_CTRL = 5'h00;   // encoder_control
  localparam logic [AW-1:0] OFF_POS = 5'h04;    // position counter
  localparam logic [AW-1:0] OFF_MAX = 5'h08;    // max_count_value
  localparam logic [AW-1:0] OFF_STAT = 5'h0C;   // event status, write one to clear
  localparam logic [AW-1:0] OFF_MASK = 5'h10;   // event mask

  // ----------------------------------------
  // encoder_control field positions
  // ----------------------------------------
  localparam int B_ERR = 15;                    // count_error_flag
  localparam int B_IDLE = 13;                   // idle_halt_select
  localparam int B_INDEX = 12;                  // index_pin_level, read only
  localparam int B_DIR = 11;                    // count_direction_status
  localparam int B_MODE = 8;                    // encoder_mode_select, 3 bits
  localparam int B_SWAP = 7;                    // phase_swap_select
  localparam int B_DOUT = 6;                    // direction_output_enable
  localparam int B_GATE = 5;                    // timer_gate_enable
  localparam int B_PS = 3;                      // timer_prescale_select, 2 bits
  localparam int B_INDEX_RESET_ENABLE = 2;                  // index_reset_enable
  localparam int B_TCS = 1;                     // timer_clock_source
  localparam int B_DSRC = 0;                    // direction_source_select
  localparam logic [15:0] CTRL_RST = 16'h0000;  // control reset value
  localparam logic [15:0] CTRL_WMASK = 16'h2FFF; // plainly writable bits

  // ----------------------------------------
  // status bits, resets, timer prescale limits
  // ----------------------------------------
  localparam int ST_ERR = 0;                    // count error event
  localparam int ST_WRAP = 1;                   // max match or underflow event
  localparam int ST_IDX = 2;                    // index reset event
  localparam int ST_W = 3;                      // status width
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;  // all events masked at reset
  localparam logic [7:0] PS_L0 = 8'h00;         // divide by 1
  localparam logic [7:0] PS_L1 = 8'h07;         // divide by 8
  localparam logic [7:0] PS_L2 = 8'h3F;         // divide by 64
  localparam logic [7:0] PS_L3 = 8'hFF;         // divide by 256

  // mode field encodings
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000, MODE_TMR = 3'b001, MODE_UN2 = 3'b010, MODE_UN3 = 3'b011,
    MODE_X2IDX = 3'b100, MODE_X2MAX = 3'b101, MODE_X4IDX = 3'b110, MODE_X4MAX = 3'b111
  } qec_mode_t;

endpackage

// file: verilog/qec_dec_if.sv
// interface between the encoder core and its pin decoder
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface qec_dec_if;
  logic en;        // decoding allowed
  logic swap;      // exchange phases
  logic x4;        // x4 counting, else x2
  logic step;      // one count step
  logic up;        // step direction
  logic idx_lvl;   // filtered index level
  logic idx_rise;  // index rising edge
  logic pha_lvl;   // filtered phase a, unswapped
  logic pha_rise;  // phase a rising edge, unswapped
  logic phb_lvl;   // filtered phase b, unswapped
  modport dec (input en, swap, x4,
               output step, up, idx_lvl, idx_rise, pha_lvl, pha_rise, phb_lvl);
  modport core (output en, swap, x4,
                input step, up, idx_lvl, idx_rise, pha_lvl, pha_rise, phb_lvl);
endinterface

// file: verilog/qec_decode.sv
// pin synchroniser and quadrature decoder of the encoder block
// assumes asynchronous encoder pins and a core on the same clock
`timescale 1ns/1ps
module qec_decode (
  input logic i_clk,       // core clock
  input logic i_rst_b,     // async reset, active low
  input logic i_pha,       // phase a pin
  input logic i_phb,       // phase b pin
  input logic i_idx,       // index pin
  qec_dec_if.dec dif       // decoder side
);
  import qec_pkg::*;

  logic [2:0] pin_w;       // pins as one vector
  logic [2:0] s1_q;        // first sync stage
  logic [2:0] s2_q;        // second sync stage
  logic [2:0] s3_q;        // third sync stage
  logic [2:0] flt_q;       // accepted levels
  logic a_q;               // previous decoded a
  logic b_q;               // previous decoded b
  logic idx_q;             // previous index
  logic pa_q;              // previous raw phase a
  logic a_w;               // decoded a
  logic b_w;               // decoded b

  assign pin_w = {i_idx, i_phb, i_pha};

  // ----------------------------------------
  // three-stage sync, change taken once stages two and three agree
  // ----------------------------------------
  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        s1_q[g] <= 1'b0;
        s2_q[g] <= 1'b0;
        s3_q[g] <= 1'b0;
        flt_q[g] <= 1'b0;
      end else begin
        s1_q[g] <= pin_w[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g]) begin
          flt_q[g] <= s3_q[g];
        end
      end
    end
  end

  // swap exchanges the phases before decoding
  assign a_w = dif.swap ? flt_q[1] : flt_q[0];
  assign b_w = dif.swap ? flt_q[0] : flt_q[1];

  // previous samples for edge and transition detection
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      idx_q <= 1'b0;
      pa_q <= 1'b0;
    end else begin
      a_q <= a_w;
      b_q <= b_w;
      idx_q <= flt_q[2];
      pa_q <= flt_q[0];
    end
  end

  // x4 counts any single-phase edge, x2 only phase a edges; double edges dropped
  assign dif.step = dif.en & (dif.x4 ? ((a_w ^ a_q) ^ (b_w ^ b_q))
                                     : ((a_w ^ a_q) & ~(b_w ^ b_q)));
  assign dif.up = a_w ^ b_q;       // a leading b counts up
  assign dif.idx_lvl = flt_q[2];
  assign dif.idx_rise = flt_q[2] & ~idx_q;
  assign dif.pha_lvl = flt_q[0];
  assign dif.pha_rise = flt_q[0] & ~pa_q;
  assign dif.phb_lvl = flt_q[1];

  // a step never comes from a double-phase change
  chk_step_single_phase: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    dif.step |-> ((a_w ^ a_q) != (b_w ^ b_q)))
    else $error("step taken on a double-phase change");

endmodule

// file: verif/qec_enc_model.sv
// behavioural incremental encoder: gray phases, one quarter step per request
// assumes the bench spaces steps at least 3 clocks apart
`timescale 1ns/1ps
module qec_enc_model (
  input logic i_clk,   // bench clock
  input logic i_step,  // advance one quarter step
  input logic i_fwd,   // 1: phase a leads phase b
  input logic i_index, // index request
  output logic o_pha,  // phase a pin
  output logic o_phb,  // phase b pin
  output logic o_idx   // index pin
);
  logic [1:0] pos_q = 2'h0; // quarter position, 0..3
  // step the gray position, pins stay put between steps
  always @(posedge i_clk) begin
    if (i_step) pos_q <= i_fwd ? pos_q + 2'h1 : pos_q - 2'h1;
  end
  assign o_pha = pos_q[0] ^ pos_q[1]; // 0,1,1,0 over a cycle
  assign o_phb = pos_q[1];            // 0,0,1,1 over a cycle
  assign o_idx = i_index;             // index follows request
endmodule

// file: verif/testbench.sv
// self-checking bench of the encoder block against a behavioural encoder
// assumes a slave that answers by lowering waitrequest, pins seen a few edges late
`timescale 1ns/1ps
module testbench;
  import qec_pkg::*;
  logic i_clk = 0, i_rst_b = 0, rd = 0, wr = 0, stp = 0, fwd = 1, ixr = 0, idl = 0;
  logic [AW-1:0] ad = '0;
  logic [31:0] wd = '0, rq, rdv;
  logic [3:0] be = 4'hF;
  logic wq, pa, pb, px, dir, doe, irq;
  logic [15:0] r;
  int miscompares = 0, compares = 0;
  always #4 i_clk = ~i_clk;
  qec_enc_model i_qec_enc_model (.i_clk(i_clk), .i_step(stp), .i_fwd(fwd),
    .i_index(ixr), .o_pha(pa), .o_phb(pb), .o_idx(px));
  qec_encoder i_qec_encoder (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(ad),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rq), .o_avs_waitrequest(wq), .i_pha(pa), .i_phb(pb), .i_idx(px),
    .i_idle(idl), .o_dir(dir), .o_dir_oe(doe), .o_irq(irq));
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    rd <= ~w; wr <= w; ad <= a; wd <= d;
    // waitrequest and read data are both taken at the same rising edge
    do begin @(posedge i_clk); n++; end while (wq !== 1'b0 && n < 20);
    rdv = rq;
    rd <= 0; wr <= 0;
    if (n >= 20) miscompares++;
  endtask
  task automatic rchk(input string nm, input logic [AW-1:0] a, input logic [31:0] e);
    bus(0, a, 32'h0000_0000);
    check(nm, rdv, e);
  endtask
  // quarter steps spaced well above the filter length
  task automatic steps(input int n, input logic f);
    repeat (n) begin
      @(posedge i_clk); fwd <= f; stp <= 1;
      @(posedge i_clk); stp <= 0;
      repeat (6) @(posedge i_clk);
    end
    repeat (8) @(posedge i_clk);
  endtask
  function automatic int ecnt(input logic [2:0] m);
    return m[2] ? (m[1] ? 4 : 2) : 0; // full cycle: x4 four, x2 two
  endfunction
  initial begin
    #200000;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    r = 16'($urandom(32'h6172));
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1;
    rchk("ctrl rst", OFF_CTRL, 32'h0000_0000);
    rchk("max rst", OFF_MAX, 32'h0000_FFFF);
    rchk("unmapped", 5'h14, 32'h0000_0000);
    // every mode, prescale and direction source set in encoder modes
    for (int m = 0; m < 8; m++) begin
      r = 16'($urandom) & 16'h0FFF;
      bus(1, OFF_CTRL, (m << B_MODE) | (m > 3 ? 32'h0000_0019 : 32'h0000_0000));
      bus(1, OFF_POS, {16'h0000, r});
      steps(4, 1);
      bus(0, OFF_POS, 32'h0000_0000);
      if (m == 1) check("timer", 32'(rdv[15:0] == r), 32'h0000_0000);
      else check("count", rdv, r + ecnt(m));
    end
    // swapped phases count down, direction pin driven
    bus(1, OFF_CTRL, 32'h0000_07C0);
    bus(1, OFF_POS, 32'h0000_0000);
    steps(4, 1);
    rchk("swap pos", OFF_POS, 32'h0000_FFFC);
    check("dir oe", 32'(doe), 32'h0000_0001);
    check("dir pin", 32'(dir), 32'h0000_0000);
    bus(1, OFF_CTRL, 32'h0000_0FC0);
    rchk("dir ro", OFF_CTRL, 32'h0000_07C0);
    // idle halt freezes counting
    bus(1, OFF_CTRL, 32'h0000_2700);
    bus(1, OFF_POS, 32'h0000_0000);
    idl <= 1;
    steps(4, 1);
    rchk("idle", OFF_POS, 32'h0000_0000);
    idl <= 0;
    // wrap at max, masked then unmasked interrupt, write one to clear
    bus(1, OFF_CTRL, 32'h0000_0700);
    bus(1, OFF_MAX, 32'h0000_0002);
    steps(4, 1);
    rchk("wrap", OFF_POS, 32'h0000_0001);
    rchk("no err", OFF_CTRL, 32'h0000_0F00);
    check("irq masked", 32'(irq), 32'h0000_0000);
    bus(1, OFF_MASK, 32'h0000_0002);
    @(posedge i_clk); // mask lands on the answering edge, irq settles after it
    check("irq", 32'(irq), 32'h0000_0001);
    bus(1, OFF_STAT, 32'h0000_0002);
    @(posedge i_clk);
    check("irq clr", 32'(irq), 32'h0000_0000);
    // index reset, index level, count error and its clearing
    bus(1, OFF_CTRL, 32'h0000_0604);
    bus(1, OFF_POS, 32'h0000_0005);
    ixr <= 1;
    repeat (8) @(posedge i_clk);
    bus(0, OFF_CTRL, 32'h0000_0000);
    check("idx lvl", 32'(rdv[B_INDEX]), 32'h0000_0001);
    ixr <= 0;
    rchk("idx reset", OFF_POS, 32'h0000_0000);
    steps(3, 1);
    bus(0, OFF_CTRL, 32'h0000_0000);
    check("err set", 32'(rdv[B_ERR]), 32'h0000_0001);
    be <= 4'h1;
    bus(1, OFF_CTRL, 32'h0000_0604);
    be <= 4'hF;
    bus(0, OFF_CTRL, 32'h0000_0000);
    check("err kept", 32'(rdv[B_ERR]), 32'h0000_0001);
    bus(1, OFF_CTRL, 32'h0000_0604);
    bus(0, OFF_CTRL, 32'h0000_0000);
    check("err clr", 32'(rdv[B_ERR]), 32'h0000_0000);
    // x2 index reset, then an x2 underflow loads the max count
    bus(1, OFF_CTRL, 32'h0000_0404);
    bus(1, OFF_POS, 32'h0000_0007);
    ixr <= 1;
    repeat (8) @(posedge i_clk);
    ixr <= 0;
    rchk("x2 idx", OFF_POS, 32'h0000_0000);
    bus(1, OFF_CTRL, 32'h0000_0500);
    bus(1, OFF_POS, 32'h0000_0000);
    steps(2, 0);
    rchk("x2 under", OFF_POS, 32'h0000_0002);
    check("x2 dir", 32'(dir), 32'h0000_0000);
    // timer counting up through the divide-by-256 prescaler
    bus(1, OFF_CTRL, 32'h0000_0100);
    bus(1, OFF_CTRL, 32'h0000_0918);
    bus(1, OFF_POS, 32'h0000_0000);
    repeat (300) @(posedge i_clk);
    rchk("timer up", OFF_POS, 32'h0000_0001);
    tally_and_finish;
  end
endmodule
